// ===== fifo_pkg.sv
// constants shared by both ends of the deep synchronous fifo link
// assumes one system clock of 250 MHz on each end
`default_nettype none
package fifo_pkg;
  // word and depth
  localparam int DATA_W = 18;
  localparam int DEPTH_32K = 32768;
  localparam int DEPTH_64K = 65536;
  // offset register reset values, in words
  localparam int EMPTY_OFFSET_RST = 127;
  localparam int FULL_OFFSET_RST = 127;
  // timing of the pin clocks the host makes
  localparam int MCLK_PERIOD_NS = 4;
  localparam int LINK_CLK_PERIOD_NS = 32;
  localparam int LINK_CLK_DIV = LINK_CLK_PERIOD_NS / MCLK_PERIOD_NS;
  // link clock periods the host holds the fifo reset
  localparam int HOST_RESET_PERIODS = 4;
  typedef enum logic {
    H_RESET = 1'b0,
    H_RUN = 1'b1
  } host_state_e;
endpackage : fifo_pkg
`default_nettype wire

// ===== fifo_pins_if.sv
// pin bundle between the fifo device and the host that writes and reads it
// assumes the testbench instantiates it and passes the modports to both ends
`default_nettype none
interface fifo_pins_if #(
  parameter int DW = fifo_pkg::DATA_W
);
  logic write_clk;
  logic write_en_n;
  logic [DW-1:0] write_data;
  logic read_clk;
  logic read_en_n;
  logic [DW-1:0] read_data;
  logic offset_load_n;
  logic fifo_reset_n;
  logic empty_indicator_n;
  logic full_indicator_n;
  logic almost_empty_indicator_n;
  logic almost_full_indicator_n;

  modport device_mp (
    input write_clk, write_en_n, write_data, read_clk, read_en_n,
    input offset_load_n, fifo_reset_n,
    output read_data, empty_indicator_n, full_indicator_n,
    output almost_empty_indicator_n, almost_full_indicator_n
  );
  modport host_mp (
    output write_clk, write_en_n, write_data, read_clk, read_en_n,
    output offset_load_n, fifo_reset_n,
    input read_data, empty_indicator_n, full_indicator_n,
    input almost_empty_indicator_n, almost_full_indicator_n
  );
endinterface : fifo_pins_if
`default_nettype wire

// ===== fifo_device.sv
// deep synchronous fifo device: storage, status flags, offset register, tokens
// assumes every pin arrives unsynchronised and is sampled on mclk_in
`default_nettype none
module fifo_device #(
  parameter int DEPTH = fifo_pkg::DEPTH_32K,
  parameter int DW = fifo_pkg::DATA_W,
  parameter bit CASCADE_EN = 1'b0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // pins toward the host
  fifo_pins_if.device_mp pins,
  // cascade and mode pins
  input wire logic write_token_in_n_in,
  input wire logic read_token_in_n_in,
  input wire logic first_in_chain_n_in,
  input wire logic sync_almost_select_in,
  output logic write_token_out_n_out,
  output logic read_token_out_n_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int SW = DW + 10;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);

  // two-stage sampling of every pin
  logic [SW-1:0] pin_s1_reg;
  logic [SW-1:0] pin_s2_reg;
  wire logic [SW-1:0] pin_raw;
  assign pin_raw = {pins.write_clk, pins.read_clk, pins.write_en_n, pins.read_en_n,
                    pins.offset_load_n, pins.fifo_reset_n, write_token_in_n_in,
                    read_token_in_n_in, first_in_chain_n_in, sync_almost_select_in,
                    pins.write_data};

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire logic wclk_s;
  wire logic rclk_s;
  wire logic wen_n_s;
  wire logic ren_n_s;
  wire logic load_n_s;
  wire logic reset_n_s;
  wire logic wti_n_s;
  wire logic rti_n_s;
  wire logic first_n_s;
  wire logic sync_almost_select_s;
  wire logic [DW-1:0] data_s;
  assign {wclk_s, rclk_s, wen_n_s, ren_n_s, load_n_s, reset_n_s, wti_n_s, rti_n_s,
          first_n_s, sync_almost_select_s, data_s} = pin_s2_reg;

  // edge history of the sampled clocks and token inputs
  logic wclk_prev_reg;
  logic rclk_prev_reg;
  logic wti_prev_reg;
  logic rti_prev_reg;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wclk_prev_reg <= 1'b0;
      rclk_prev_reg <= 1'b0;
      wti_prev_reg <= 1'b1;
      rti_prev_reg <= 1'b1;
    end else begin
      wclk_prev_reg <= wclk_s;
      rclk_prev_reg <= rclk_s;
      wti_prev_reg <= wti_n_s;
      rti_prev_reg <= rti_n_s;
    end
  end

  // state
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] off_empty_reg;
  logic [CW-1:0] off_full_reg;
  logic off_wsel_reg;
  logic off_rsel_reg;
  logic wtok_reg;
  logic rtok_reg;
  logic empty_n_reg;
  logic full_n_reg;
  logic almost_empty_n_reg;
  logic almost_full_n_reg;
  logic wxo_reg;
  logic rxo_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] mem_q [DEPTH];

  // decode of one access per sampled clock edge
  wire logic w_edge;
  wire logic r_edge;
  wire logic soft_rst;
  wire logic ld_active;
  wire logic wr_take;
  wire logic rd_take;
  wire logic off_wr;
  wire logic off_rd;
  wire logic wti_fall;
  wire logic rti_fall;
  assign w_edge = wclk_s & ~wclk_prev_reg;
  assign r_edge = rclk_s & ~rclk_prev_reg;
  assign soft_rst = ~reset_n_s;
  assign ld_active = ~load_n_s;
  assign wr_take = w_edge & ~wen_n_s & ~ld_active & full_n_reg & wtok_reg & ~soft_rst;
  assign rd_take = r_edge & ~ren_n_s & ~ld_active & empty_n_reg & rtok_reg & ~soft_rst;
  assign off_wr = w_edge & ~wen_n_s & ld_active & ~soft_rst;
  assign off_rd = r_edge & ~ren_n_s & ld_active & ~soft_rst;
  assign wti_fall = wti_prev_reg & ~wti_n_s;
  assign rti_fall = rti_prev_reg & ~rti_n_s;

  // fill level after this cycle, both ports at once
  wire logic [CW-1:0] count_next;
  wire logic [CW-1:0] space_next;
  assign count_next = count_reg + CW'(wr_take) - CW'(rd_take);
  assign space_next = DEPTH_C - count_next;

  // token hand-over for depth cascade
  wire logic wxo_pulse;
  wire logic rxo_pulse;
  wire logic almost_live;
  assign wxo_pulse = CASCADE_EN & wr_take & (count_next == DEPTH_C);
  assign rxo_pulse = CASCADE_EN & rd_take & (count_next == '0) & ~wtok_reg;
  assign almost_live = sync_almost_select_s;

  // storage
  always_ff @(posedge mclk_in) begin
    if (wr_take) begin
      mem_q[wptr_reg] <= data_s;
    end
  end

  // pointers, level and offsets
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      off_empty_reg <= CW'(fifo_pkg::EMPTY_OFFSET_RST);
      off_full_reg <= CW'(fifo_pkg::FULL_OFFSET_RST);
      off_wsel_reg <= 1'b0;
      off_rsel_reg <= 1'b0;
    end else if (soft_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      off_empty_reg <= CW'(fifo_pkg::EMPTY_OFFSET_RST);
      off_full_reg <= CW'(fifo_pkg::FULL_OFFSET_RST);
      off_wsel_reg <= 1'b0;
      off_rsel_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_reg + AW'(wr_take);
      rptr_reg <= rptr_reg + AW'(rd_take);
      count_reg <= count_next;
      if (off_wr) begin
        off_wsel_reg <= ~off_wsel_reg;
        if (off_wsel_reg) begin
          off_full_reg <= data_s[CW-1:0];
        end else begin
          off_empty_reg <= data_s[CW-1:0];
        end
      end
      if (off_rd) begin
        off_rsel_reg <= ~off_rsel_reg;
      end
    end
  end

  // read data register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
    end else if (rd_take) begin
      rdata_reg <= mem_q[rptr_reg];
    end else if (off_rd) begin
      rdata_reg <= off_rsel_reg ? DW'(off_full_reg) : DW'(off_empty_reg);
    end
  end

  // status flags, each on its owning edge; almost flags every cycle while sync_almost_select_in is high
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      empty_n_reg <= 1'b0;
      full_n_reg <= 1'b1;
      almost_empty_n_reg <= 1'b0;
      almost_full_n_reg <= 1'b1;
    end else if (soft_rst) begin
      empty_n_reg <= 1'b0;
      full_n_reg <= 1'b1;
      almost_empty_n_reg <= 1'b0;
      almost_full_n_reg <= 1'b1;
    end else begin
      if (r_edge) begin
        empty_n_reg <= (count_next != '0);
      end
      if (w_edge) begin
        full_n_reg <= (count_next != DEPTH_C);
      end
      if (r_edge | almost_live) begin
        almost_empty_n_reg <= ~(count_next <= off_empty_reg);
      end
      if (w_edge | almost_live) begin
        almost_full_n_reg <= ~(space_next <= off_full_reg);
      end
    end
  end

  // token ownership and the dual-use output pin
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wtok_reg <= 1'b0;
      rtok_reg <= 1'b0;
      wxo_reg <= 1'b1;
      rxo_reg <= 1'b1;
    end else begin
      if (soft_rst) begin
        wtok_reg <= ~CASCADE_EN | ~first_n_s;
        rtok_reg <= ~CASCADE_EN | ~first_n_s;
      end else begin
        if (wxo_pulse) begin
          wtok_reg <= 1'b0;
        end else if (CASCADE_EN & wti_fall) begin
          wtok_reg <= 1'b1;
        end
        if (rxo_pulse) begin
          rtok_reg <= 1'b0;
        end else if (CASCADE_EN & rti_fall) begin
          rtok_reg <= 1'b1;
        end
      end
      wxo_reg <= CASCADE_EN ? ~wxo_pulse : ~(count_next > HALF_C);
      rxo_reg <= ~rxo_pulse;
    end
  end

  // outputs straight from flip-flops
  assign pins.read_data = rdata_reg;
  assign pins.empty_indicator_n = empty_n_reg;
  assign pins.full_indicator_n = full_n_reg;
  assign pins.almost_empty_indicator_n = almost_empty_n_reg;
  assign pins.almost_full_indicator_n = almost_full_n_reg;
  assign write_token_out_n_out = wxo_reg;
  assign read_token_out_n_out = rxo_reg;
  // read port runs from its own sampled clock and enable
  // depth and width fixed by DEPTH and DW
endmodule : fifo_device
`default_nettype wire

// ===== fifo_host.sv
// host end: makes the shared write/read pin clock, drives enables and data
// assumes the device samples pins on a clock of the same rate
`default_nettype none
module fifo_host #(
  parameter int DW = fifo_pkg::DATA_W,
  parameter int DIV = fifo_pkg::LINK_CLK_DIV
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // pins toward the device
  fifo_pins_if.host_mp pins,
  // user write side
  input wire logic wr_valid_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic offset_write_in,
  output logic wr_accept_out,
  // user read side
  input wire logic rd_req_in,
  input wire logic offset_read_in,
  output logic [DW-1:0] rd_data_out,
  output logic rd_valid_out,
  // control
  input wire logic reset_req_in,
  output logic ready_out
);
  localparam int PW = $clog2(DIV);
  localparam int HALF = DIV / 2;
  localparam int RW = $clog2(fifo_pkg::HOST_RESET_PERIODS + 1);

  // empty and full flags and read data sampled through two stages
  logic [DW+1:0] in_s1_reg;
  logic [DW+1:0] in_s2_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end else begin
      in_s1_reg <= {pins.empty_indicator_n, pins.full_indicator_n, pins.read_data};
      in_s2_reg <= in_s1_reg;
    end
  end
  wire logic empty_n_s;
  wire logic full_n_s;
  wire logic [DW-1:0] rdata_s;
  assign {empty_n_s, full_n_s, rdata_s} = in_s2_reg;

  // clock divider; decisions come one phase after the pin clock falls, once the
  // flags and read data of the last rising edge are back through both stages
  logic [PW-1:0] phase_reg;
  logic clk_reg;
  wire logic [PW-1:0] phase_next;
  wire logic decide;
  assign phase_next = (phase_reg == PW'(DIV - 1)) ? '0 : phase_reg + PW'(1);
  assign decide = (phase_reg == PW'(HALF + 1));

  fifo_pkg::host_state_e state_reg;
  logic [RW-1:0] rcnt_reg;
  logic reset_n_reg;
  logic wen_n_reg;
  logic ren_n_reg;
  logic load_n_reg;
  logic [DW-1:0] wdata_reg;
  logic rd_pend_reg;

  wire logic cfg;
  wire logic do_w;
  wire logic do_r;
  assign cfg = offset_write_in | offset_read_in;
  assign do_w = offset_write_in | (~cfg & wr_valid_in & full_n_s);
  assign do_r = offset_read_in | (~cfg & rd_req_in & empty_n_s);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= '0;
      clk_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      clk_reg <= (phase_next < PW'(HALF));
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= fifo_pkg::H_RESET;
      rcnt_reg <= '0;
      reset_n_reg <= 1'b0;
      wen_n_reg <= 1'b1;
      ren_n_reg <= 1'b1;
      load_n_reg <= 1'b1;
      wdata_reg <= '0;
      rd_pend_reg <= 1'b0;
      wr_accept_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else begin
      wr_accept_out <= 1'b0;
      rd_valid_out <= 1'b0;
      if (decide) begin
        case (state_reg)
          fifo_pkg::H_RESET: begin
            reset_n_reg <= 1'b0;
            wen_n_reg <= 1'b1;
            ren_n_reg <= 1'b1;
            load_n_reg <= 1'b1;
            rd_pend_reg <= 1'b0;
            rcnt_reg <= rcnt_reg + RW'(1);
            if (rcnt_reg == RW'(fifo_pkg::HOST_RESET_PERIODS - 1)) begin
              state_reg <= fifo_pkg::H_RUN;
              reset_n_reg <= 1'b1;
            end
          end
          fifo_pkg::H_RUN: begin
            rcnt_reg <= '0;
            rd_pend_reg <= do_r & ~reset_req_in;
            if (rd_pend_reg) begin
              rd_data_out <= rdata_s;
              rd_valid_out <= 1'b1;
            end
            if (reset_req_in) begin
              state_reg <= fifo_pkg::H_RESET;
              reset_n_reg <= 1'b0;
              wen_n_reg <= 1'b1;
              ren_n_reg <= 1'b1;
              load_n_reg <= 1'b1;
            end else begin
              wen_n_reg <= ~do_w;
              ren_n_reg <= ~do_r;
              load_n_reg <= ~cfg;
              wr_accept_out <= do_w;
              if (do_w) begin
                wdata_reg <= wr_data_in;
              end
            end
          end
          default: begin
            state_reg <= fifo_pkg::H_RESET;
          end
        endcase
      end
    end
  end

  assign pins.write_clk = clk_reg;
  assign pins.read_clk = clk_reg;
  assign pins.write_en_n = wen_n_reg;
  assign pins.read_en_n = ren_n_reg;
  assign pins.offset_load_n = load_n_reg;
  assign pins.write_data = wdata_reg;
  assign pins.fifo_reset_n = reset_n_reg;
  assign ready_out = state_reg;
endmodule : fifo_host
`default_nettype wire

// ===== fifo_link_assertions.sv
// checker on the pin link between the fifo host and the fifo device
// assumes the testbench wires it to the pin interface and the system clock
`default_nettype none
module fifo_link_assertions #(
  parameter int DW = fifo_pkg::DATA_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // pin link
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic fifo_reset_n,
  input wire logic [DW-1:0] read_data,
  input wire logic empty_indicator_n,
  input wire logic full_indicator_n,
  input wire logic almost_empty_indicator_n,
  input wire logic almost_full_indicator_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wclk_reg;
  logic rclk_reg;
  logic rsn_reg;
  logic [3:0] w_age_reg;
  logic [3:0] r_age_reg;
  logic [3:0] rs_age_reg;
  // mclk cycles since a pin clock rose, or since the fifo reset pin moved
  wire [3:0] w_age_next = (write_clk && !wclk_reg) ? 4'h0 : w_age_reg + 4'(w_age_reg != 4'hf);
  wire [3:0] r_age_next = (read_clk && !rclk_reg) ? 4'h0 : r_age_reg + 4'(r_age_reg != 4'hf);
  wire [3:0] rs_age_next = (fifo_reset_n != rsn_reg) ? 4'h0 : rs_age_reg + 4'(rs_age_reg != 4'hf);
  wire quiet = !fifo_reset_n || rs_age_reg < 4'ha;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wclk_reg <= 1'h0;
      rclk_reg <= 1'h0;
      rsn_reg <= 1'h0;
      w_age_reg <= 4'hf;
      r_age_reg <= 4'hf;
      rs_age_reg <= 4'h0;
    end else begin
      wclk_reg <= write_clk;
      rclk_reg <= read_clk;
      rsn_reg <= fifo_reset_n;
      w_age_reg <= w_age_next;
      r_age_reg <= r_age_next;
      rs_age_reg <= rs_age_next;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  chk_empty_read_edge: assert property (
    !quiet && $changed(empty_indicator_n) |-> r_age_reg inside {[1:6]})
    else $error("empty flag moved away from a read edge");
  chk_full_write_edge: assert property (
    !quiet && $changed(full_indicator_n) |-> w_age_reg inside {[1:6]})
    else $error("full flag moved away from a write edge");
  chk_almost_empty_sync: assert property (
    !quiet && $changed(almost_empty_indicator_n) |-> r_age_reg inside {[1:6]})
    else $error("almost empty flag not tied to read edges");
  chk_almost_full_sync: assert property (
    !quiet && $changed(almost_full_indicator_n) |-> w_age_reg inside {[1:6]})
    else $error("almost full flag not tied to write edges");
  chk_data_read_edge: assert property (
    !quiet && $changed(read_data) |-> r_age_reg inside {[1:6]})
    else $error("read data moved away from a read edge");
  chk_flag_hold_cycle: assert property (
    !quiet && $changed(empty_indicator_n) |=> $stable(empty_indicator_n) [*4])
    else $error("empty flag did not hold");
  chk_empty_not_full: assert property (
    empty_indicator_n || full_indicator_n)
    else $error("empty and full flags both low");
  chk_empty_almost_low: assert property (
    !empty_indicator_n |-> !almost_empty_indicator_n)
    else $error("almost empty high while empty");
  chk_fifo_reset_clear: assert property (
    !fifo_reset_n && rs_age_reg == 4'h8 |->
      !empty_indicator_n && full_indicator_n && !almost_empty_indicator_n)
    else $error("fifo reset did not empty the buffer");
endmodule : fifo_link_assertions
`default_nettype wire

// ===== deep_sync_fifo_18bit_tb.sv
// testbench: fifo host and a stand-alone fifo device joined by the pin interface
// assumes the package, the interface and both ends are compiled before it
`default_nettype none
module deep_sync_fifo_18bit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 16;
  localparam int DW = fifo_pkg::DATA_W;
  logic mclk_in;
  logic rst_in;
  logic wr_valid;
  logic [DW-1:0] wr_data;
  logic offset_write;
  logic wr_accept;
  logic rd_req;
  logic offset_read;
  logic [DW-1:0] rd_data;
  logic rd_valid;
  logic reset_req;
  logic ready;
  logic wtok_n;
  logic rtok_n;
  int n_mismatch = 0;
  int check_count = 0;
  logic [DW-1:0] got[$];

  fifo_pins_if #(.DW(DW)) fifo_pins_if_inst ();
  // order: empty, almost empty, half, almost full, full, read token
  wire [5:0] flag_vec = {fifo_pins_if_inst.empty_indicator_n,
    fifo_pins_if_inst.almost_empty_indicator_n, wtok_n,
    fifo_pins_if_inst.almost_full_indicator_n, fifo_pins_if_inst.full_indicator_n, rtok_n};

  fifo_device #(.DEPTH(DEPTH), .DW(DW), .CASCADE_EN(1'h0)) fifo_device_inst (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pins(fifo_pins_if_inst),
    .write_token_in_n_in(1'h0),
    .read_token_in_n_in(1'h0),
    .first_in_chain_n_in(1'h0),
    .sync_almost_select_in(1'h0),
    .write_token_out_n_out(wtok_n),
    .read_token_out_n_out(rtok_n)
  );
  fifo_host #(.DW(DW)) fifo_host_inst (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pins(fifo_pins_if_inst),
    .wr_valid_in(wr_valid),
    .wr_data_in(wr_data),
    .offset_write_in(offset_write),
    .wr_accept_out(wr_accept),
    .rd_req_in(rd_req),
    .offset_read_in(offset_read),
    .rd_data_out(rd_data),
    .rd_valid_out(rd_valid),
    .reset_req_in(reset_req),
    .ready_out(ready)
  );
  fifo_link_assertions fifo_link_assertions_inst (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .write_clk(fifo_pins_if_inst.write_clk),
    .read_clk(fifo_pins_if_inst.read_clk),
    .fifo_reset_n(fifo_pins_if_inst.fifo_reset_n),
    .read_data(fifo_pins_if_inst.read_data),
    .empty_indicator_n(fifo_pins_if_inst.empty_indicator_n),
    .full_indicator_n(fifo_pins_if_inst.full_indicator_n),
    .almost_empty_indicator_n(fifo_pins_if_inst.almost_empty_indicator_n),
    .almost_full_indicator_n(fifo_pins_if_inst.almost_full_indicator_n)
  );

  always #2 mclk_in = ~mclk_in;

  always @(posedge mclk_in) begin
    if (rd_valid === 1'h1) begin
      got.push_back(rd_data);
    end
  end

  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : wait_cyc

  task automatic wait_ready();
    int g;
    g = 0;
    wait_cyc(4);
    while (ready !== 1'h1 && g < 300) begin
      @(posedge mclk_in);
      g++;
    end
    #1;
    check("ready", DW'(ready), DW'(1));
  endtask : wait_ready

  // holds valid across words so the host writes back to back
  task automatic wr_n(input int n, input logic [DW-1:0] base, input logic offs);
    int g;
    wr_valid = 1'h1;
    offset_write = offs;
    for (int i = 0; i < n; i++) begin
      wr_data = base + DW'(i);
      g = 0;
      do begin
        @(posedge mclk_in);
        g++;
      end while (wr_accept !== 1'h1 && g < 40);
      #1;
      check("write spacing", (i == 0) ? DW'(g <= 9) : DW'(g), (i == 0) ? DW'(1) : DW'(8));
    end
    wr_valid = 1'h0;
    offset_write = 1'h0;
    wait_cyc(20);
  endtask : wr_n

  // counts pin read clock rises with read enable low
  task automatic rd_n(input int n, input logic offs);
    int k;
    int g;
    k = 0;
    g = 0;
    rd_req = 1'h1;
    offset_read = offs;
    while (k < n && g < n + 4) begin
      @(posedge fifo_pins_if_inst.read_clk);
      g++;
      if (fifo_pins_if_inst.read_en_n === 1'h0) begin
        k++;
      end
    end
    #1;
    rd_req = 1'h0;
    offset_read = 1'h0;
    wait_cyc(24);
  endtask : rd_n

  task automatic take(input string what, input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    v = 'x;
    if (got.size() > 0) begin
      v = got.pop_front();
    end
    check(what, v, exp);
  endtask : take

  task automatic t_offsets();
    wr_n(2, DW'(2), 1'h1); // empty offset 2 then full offset 3
    wr_n(1, 18'h2a5a5, 1'h0);
    rd_n(2, 1'h1);
    take("empty offset", 18'h00002);
    take("full offset", 18'h00003);
    rd_n(1, 1'h0);
    take("word behind offsets", 18'h2a5a5);
    check("flags idle", DW'(flag_vec), DW'(6'h0f));
  endtask : t_offsets

  task automatic t_fill();
    int g;
    wr_n(12, 18'h00100, 1'h0);
    check("flags at 12", DW'(flag_vec), DW'(6'h37));
    wr_n(1, 18'h0010c, 1'h0);
    check("flags at 13", DW'(flag_vec), DW'(6'h33));
    wr_n(3, 18'h0010d, 1'h0);
    check("flags full", DW'(flag_vec), DW'(6'h31));
    g = 0;
    wr_valid = 1'h1;
    wr_data = 18'h3ffff;
    repeat (40) begin
      @(posedge mclk_in);
      g += int'(wr_accept === 1'h1);
    end
    #1;
    wr_valid = 1'h0;
    check("write while full", DW'(g), DW'(0));
    rd_n(13, 1'h0);
    check("flags at 3", DW'(flag_vec), DW'(6'h3f));
    rd_n(1, 1'h0);
    check("flags at 2", DW'(flag_vec), DW'(6'h2f));
    rd_n(2, 1'h0);
    check("flags drained", DW'(flag_vec), DW'(6'h0f));
    for (int i = 0; i < DEPTH; i++) begin
      take("fifo order", 18'h00100 + DW'(i));
    end
  endtask : t_fill

  task automatic t_reset();
    wr_n(4, 18'h3ff00, 1'h0);
    // the host looks at the request only once per link period
    reset_req = 1'h1;
    wait_cyc(fifo_pkg::LINK_CLK_DIV + 1);
    check("ready drops", DW'(ready), DW'(0));
    reset_req = 1'h0;
    wait_ready();
    // almost full follows the restored offset at the first write edge
    wait_cyc(fifo_pkg::LINK_CLK_DIV + 4);
    check("flags after reset", DW'(flag_vec), DW'(6'h0b));
    wr_n(1, 18'h15555, 1'h0);
    rd_n(1, 1'h0);
    take("first word after reset", 18'h15555);
  endtask : t_reset

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    mclk_in = 1'h0;
    rst_in = 1'h1;
    wr_valid = 1'h0;
    wr_data = '0;
    offset_write = 1'h0;
    rd_req = 1'h0;
    offset_read = 1'h0;
    reset_req = 1'h0;
    repeat (2) @(posedge mclk_in);
    #1;
    rst_in = 1'h0;
    wait_ready();
    t_offsets();
    t_fill();
    t_reset();
    final_report();
  end

  // watchdog well beyond the under a thousand cycles the scenarios need
  initial begin
    #(40000 * fifo_pkg::MCLK_PERIOD_NS);
    n_mismatch++;
    final_report();
  end
endmodule : deep_sync_fifo_18bit_tb
`default_nettype wire
